// ### logic/hj_port_pkg.sv
package hj_port_pkg;
	// Register byte offsets on the AXI4-Lite slave
	localparam logic [4:0] OFF_H_PIN = 5'h00;
	localparam logic [4:0] OFF_H_LAT = 5'h04;
	localparam logic [4:0] OFF_H_DIR = 5'h08;
	localparam logic [4:0] OFF_J_PIN = 5'h0C;
	localparam logic [4:0] OFF_J_LAT = 5'h10;
	localparam logic [4:0] OFF_J_DIR = 5'h14;
	localparam logic [4:0] OFF_G_CTL = 5'h18;
	localparam logic [4:0] OFF_ANA_CFG = 5'h1C;
	localparam int ADDR_W = 5; // Decoded address bits
	// Reset values
	localparam logic [7:0] RST_DIR = 8'hFF; // All pins inputs
	localparam logic [7:0] RST_LAT = 8'h00;
	localparam logic [3:0] RST_ANA = 4'h0; // All channels analog
	localparam logic [7:0] ALL_ON = 8'hFF;
	localparam logic [7:0] ALL_OFF = 8'h00;
	// Field positions
	localparam int G_PULLUP_BIT = 5; // Pull-up enable in the G register
	localparam int ADDR_PINS = 4; // H pins that carry address bits
	localparam int ANA_LO = 4; // First analog-capable H pin
	// AXI responses
	localparam logic [1:0] RESP_OKAY = 2'h0;
	localparam logic [1:0] RESP_SLVERR = 2'h2;
	// Overrides from the external memory interface
	typedef struct packed {
		logic ext_bus_disable; // High keeps the bus off the pins
		logic [3:0] addr_hi; // Address lines 16..19
		logic [7:0] strobes; // Bus controls, address latch enable at bit 0
	} mem_bus_t;
	// Alternate enhanced PWM outputs, bit 0 lands on H pin 4
	typedef struct packed {
		logic [3:0] level; // pwm3 c, pwm3 b, pwm1 c, pwm1 b
		logic [3:0] hiz; // Shutdown asks the pin to float
	} pwm_alt_t;
endpackage : hj_port_pkg

// ### logic/hj_port.sv
`timescale 1ns/100ps
// Operation
// R1: Direction one floats pin, zero drives latch
// R2: Latch read-modify-write uses stored latch value
// R3: Port H has eight independently directed pins
// R4: Bus enabled: H bits 0-3 carry addresses
// R5: H bits 4-7 analog channels, analog default
// R6: Swap fuse clear: PWM outputs on H 4-7
// R7: PWM pins float during shutdown when asked
// R8: Ports H and J removable by parameter
// R9: Port J has eight digital directed pins
// R10: Any reset makes all J pins inputs
// R11: Bus enabled: J pins become control outputs
// R12: J bus pins carry fixed control order
// R13: One G bit enables all J pull-ups
// R14: Pull-up off while J pin drives
// R15: Any reset disables all J pull-ups
// R16: Pin register read pins, write latch
// R17: Overrides never change stored direction bits
module hj_port
	import hj_port_pkg::*;
#(
	parameter bit HJ_PRESENT = 1'b1 // Ports exist in the large package
) (
	input wire logic aclk, // 250 MHz system clock
	input wire logic aresetn, // Synchronous reset, active low
	input wire logic [31:0] s_awaddr, // Write address
	input wire logic s_awvalid, // Write address valid
	output logic s_awready, // Write address ready
	input wire logic [31:0] s_wdata, // Write data
	input wire logic [3:0] s_wstrb, // Write byte strobes
	input wire logic s_wvalid, // Write data valid
	output logic s_wready, // Write data ready
	output logic [1:0] s_bresp, // Write response
	output logic s_bvalid, // Write response valid
	input wire logic s_bready, // Write response ready
	input wire logic [31:0] s_araddr, // Read address
	input wire logic s_arvalid, // Read address valid
	output logic s_arready, // Read address ready
	output logic [31:0] s_rdata, // Read data
	output logic [1:0] s_rresp, // Read response
	output logic s_rvalid, // Read data valid
	input wire logic s_rready, // Read data ready
	input wire hj_port_pkg::mem_bus_t mem_bus, // Memory interface drive
	input wire hj_port_pkg::pwm_alt_t pwm_alt, // Alternate PWM drive
	input wire logic pwm_pin_swap_fuse, // Clear maps PWM onto H
	output logic [3:0] analog_sel, // Converter channels 12..15 analog
	input wire logic [7:0] h_in, // Port H pin levels
	output logic [7:0] h_out, // Port H pin drive level
	output logic [7:0] h_oe, // Port H drive enable
	input wire logic [7:0] j_in, // Port J pin levels
	output logic [7:0] j_out, // Port J pin drive level
	output logic [7:0] j_oe, // Port J drive enable
	output logic [7:0] j_pullup // Port J weak pull-up enable
);
	import hj_port_pkg::*;

	// Software-visible state
	logic [7:0] h_lat_reg; // h_output_latch
	logic [7:0] h_dir_reg; // h_direction
	logic [7:0] j_lat_reg; // j_output_latch
	logic [7:0] j_dir_reg; // j_direction
	logic j_pullup_enable_reg; // Pull-up control bit of the G register
	logic [3:0] analog_pin_config_reg; // Analog pin configuration

	// Pin synchronisers, first stage feeds only the second
	logic [7:0] h_meta_reg;
	logic [7:0] h_sync_reg;
	logic [7:0] j_meta_reg;
	logic [7:0] j_sync_reg;

	// Bus slave state
	logic aw_got_reg; // Address waiting for its data
	logic w_got_reg; // Data waiting for its address
	logic [ADDR_W-1:0] awaddr_reg;
	logic [7:0] wdata_reg;
	logic wstrb_reg; // Low byte strobe
	logic [1:0] bresp_reg;
	logic bvalid_reg;
	logic [31:0] rdata_reg;
	logic [1:0] rresp_reg;
	logic rvalid_reg;

	// Pin drive registers
	logic [7:0] h_out_reg;
	logic [7:0] h_oe_reg;
	logic [7:0] j_out_reg;
	logic [7:0] j_oe_reg;
	logic [7:0] j_pullup_reg;

	// Combinational helpers
	logic aw_hs; // Address taken this edge
	logic w_hs; // Data taken this edge
	logic wr_fire; // Both halves present: perform write
	logic [ADDR_W-1:0] wr_addr;
	logic [7:0] wr_data;
	logic wr_lane0;
	logic wr_mapped;
	logic ar_hs;
	logic [ADDR_W-1:0] rd_addr;
	logic bus_en; // Memory interface owns its pins
	logic pwm_on_h; // Alternate PWM mapping active
	logic [3:0] ana_mask; // Analog channels of H pins 4..7
	logic [7:0] h_pin_read;
	logic [7:0] h_out_next;
	logic [7:0] h_oe_next;
	logic [7:0] j_out_next;
	logic [7:0] j_oe_next;

	// Write channel handshakes; one write in flight at a time
	assign s_awready = !aw_got_reg && !bvalid_reg;
	assign s_wready = !w_got_reg && !bvalid_reg;
	assign aw_hs = s_awvalid && s_awready;
	assign w_hs = s_wvalid && s_wready;
	assign wr_fire = (aw_got_reg || aw_hs) && (w_got_reg || w_hs);
	assign wr_addr = aw_got_reg ? awaddr_reg : s_awaddr[ADDR_W-1:0];
	assign wr_data = w_got_reg ? wdata_reg : s_wdata[7:0];
	assign wr_lane0 = w_got_reg ? wstrb_reg : s_wstrb[0];
	// Upper address bits must be zero for a hit
	assign wr_mapped = HJ_PRESENT && (wr_addr[1:0] == 2'h0)
		&& (wr_addr <= OFF_ANA_CFG) && ((aw_got_reg ? 1'b1
		: (s_awaddr[31:ADDR_W] == '0)));
	assign s_bvalid = bvalid_reg;
	assign s_bresp = bresp_reg;

	// Read channel; answer one cycle after address accepted
	assign s_arready = !rvalid_reg;
	assign ar_hs = s_arvalid && s_arready;
	assign rd_addr = s_araddr[ADDR_W-1:0];
	assign s_rvalid = rvalid_reg;
	assign s_rdata = rdata_reg;
	assign s_rresp = rresp_reg;

	// Pending write halves, captured in either order
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			aw_got_reg <= 1'b0;
			w_got_reg <= 1'b0;
			awaddr_reg <= '0;
			wdata_reg <= 8'h00;
			wstrb_reg <= 1'b0;
		end else if (wr_fire) begin
			aw_got_reg <= 1'b0;
			w_got_reg <= 1'b0;
		end else begin
			if (aw_hs) begin
				aw_got_reg <= 1'b1;
				// High bits folded: nonzero makes the slot unmapped
				awaddr_reg <= (s_awaddr[31:ADDR_W] == '0)
					? s_awaddr[ADDR_W-1:0] : ALL_ON[ADDR_W-1:0];
			end
			if (w_hs) begin
				w_got_reg <= 1'b1;
				wdata_reg <= s_wdata[7:0];
				wstrb_reg <= s_wstrb[0];
			end
		end
	end

	// Write response, held until the master takes it
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			bvalid_reg <= 1'b0;
			bresp_reg <= RESP_OKAY;
		end else if (wr_fire) begin
			bvalid_reg <= 1'b1;
			bresp_reg <= wr_mapped ? RESP_OKAY : RESP_SLVERR;
		end else if (s_bready) begin
			bvalid_reg <= 1'b0;
		end
	end

	// Latches: pin and latch offsets both land here
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			h_lat_reg <= RST_LAT;
			j_lat_reg <= RST_LAT;
		end else if (wr_fire && wr_mapped && wr_lane0) begin
			unique case (wr_addr)
				OFF_H_PIN, OFF_H_LAT: h_lat_reg <= wr_data; // R2 R16
				OFF_J_PIN, OFF_J_LAT: j_lat_reg <= wr_data; // R2 R16
				default: ;
			endcase
		end
	end

	// Direction bits, only software writes reach them
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			h_dir_reg <= RST_DIR;
			j_dir_reg <= RST_DIR; // R10
		end else if (wr_fire && wr_mapped && wr_lane0) begin
			// Overrides are applied at the pins only
			unique case (wr_addr)
				OFF_H_DIR: h_dir_reg <= wr_data; // R3 R17
				OFF_J_DIR: j_dir_reg <= wr_data; // R9 R17
				default: ;
			endcase
		end
	end

	// Pull-up control and analog configuration
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			j_pullup_enable_reg <= 1'b0; // R15
			analog_pin_config_reg <= RST_ANA; // R5
		end else if (wr_fire && wr_mapped && wr_lane0) begin
			unique case (wr_addr)
				OFF_G_CTL: j_pullup_enable_reg <= wr_data[G_PULLUP_BIT]; // R13
				OFF_ANA_CFG: analog_pin_config_reg <= wr_data[3:0]; // R5
				default: ;
			endcase
		end
	end

	// Two-stage synchronisers on the pin inputs
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			h_meta_reg <= ALL_OFF;
			h_sync_reg <= ALL_OFF;
			j_meta_reg <= ALL_OFF;
			j_sync_reg <= ALL_OFF;
		end else begin
			h_meta_reg <= h_in;
			h_sync_reg <= h_meta_reg;
			j_meta_reg <= j_in;
			j_sync_reg <= j_meta_reg;
		end
	end

	// Channel 12+k is analog while the config is below 4-k
	genvar k;
	generate
		for (k = 0; k < 4; k++) begin : g_ana
			assign ana_mask[k] = HJ_PRESENT
				&& (analog_pin_config_reg < 4'(4 - k)); // R5
		end
	endgenerate
	assign analog_sel = ana_mask;

	// Analog pins read zero; their digital output is untouched
	assign h_pin_read = h_sync_reg & ~{ana_mask, 4'h0}; // R5 R16

	// Read data; the latch offset returns the latch, not pins
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			rvalid_reg <= 1'b0;
			rdata_reg <= '0;
			rresp_reg <= RESP_OKAY;
		end else if (ar_hs) begin
			rvalid_reg <= 1'b1;
			rdata_reg <= '0;
			rresp_reg <= RESP_OKAY;
			if (!HJ_PRESENT || s_araddr[31:ADDR_W] != '0) begin
				rresp_reg <= RESP_SLVERR; // R8
			end else begin
				unique case (rd_addr)
					OFF_H_PIN: rdata_reg[7:0] <= h_pin_read; // R16
					OFF_H_LAT: rdata_reg[7:0] <= h_lat_reg; // R2
					OFF_H_DIR: rdata_reg[7:0] <= h_dir_reg; // R17
					OFF_J_PIN: rdata_reg[7:0] <= j_sync_reg; // R16
					OFF_J_LAT: rdata_reg[7:0] <= j_lat_reg; // R2
					OFF_J_DIR: rdata_reg[7:0] <= j_dir_reg; // R17
					OFF_G_CTL: rdata_reg[G_PULLUP_BIT] <= j_pullup_enable_reg;
					OFF_ANA_CFG: rdata_reg[3:0] <= analog_pin_config_reg;
					default: rresp_reg <= RESP_SLVERR;
				endcase
			end
		end else if (s_rready) begin
			rvalid_reg <= 1'b0;
		end
	end

	// Pin ownership: memory bus, then PWM, then port data
	assign bus_en = !mem_bus.ext_bus_disable;
	assign pwm_on_h = !pwm_pin_swap_fuse;
	always_comb begin
		h_out_next = h_lat_reg;
		h_oe_next = ~h_dir_reg; // R1 R3
		j_out_next = j_lat_reg;
		j_oe_next = ~j_dir_reg; // R1 R9
		if (bus_en) begin
			// Address ignores both latch and direction
			h_out_next[ADDR_PINS-1:0] = mem_bus.addr_hi; // R4
			h_oe_next[ADDR_PINS-1:0] = 4'hF; // R4
			j_out_next = mem_bus.strobes; // R11 R12
			j_oe_next = ALL_ON; // R11
		end
		if (pwm_on_h) begin
			// Direction still gates PWM; shutdown may float it
			h_out_next[7:ANA_LO] = pwm_alt.level; // R6
			h_oe_next[7:ANA_LO] = ~h_dir_reg[7:ANA_LO]
				& ~pwm_alt.hiz; // R7
		end
		if (!HJ_PRESENT) begin
			// Small package: no pads, nothing driven
			h_out_next = ALL_OFF; // R8
			h_oe_next = ALL_OFF;
			j_out_next = ALL_OFF;
			j_oe_next = ALL_OFF;
		end
	end

	// Registered pad drive, one cycle behind its cause
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			h_out_reg <= ALL_OFF;
			h_oe_reg <= ALL_OFF;
			j_out_reg <= ALL_OFF;
			j_oe_reg <= ALL_OFF; // R10
			j_pullup_reg <= ALL_OFF; // R15
		end else begin
			h_out_reg <= h_out_next;
			h_oe_reg <= h_oe_next;
			j_out_reg <= j_out_next;
			j_oe_reg <= j_oe_next;
			// Pull-up drops on every driven pin
			j_pullup_reg <= (HJ_PRESENT && j_pullup_enable_reg)
				? ~j_oe_next : ALL_OFF; // R13 R14
		end
	end
	assign h_out = h_out_reg;
	assign h_oe = h_oe_reg;
	assign j_out = j_out_reg;
	assign j_oe = j_oe_reg;
	assign j_pullup = j_pullup_reg;

	// Checks on the design's own behaviour
	default clocking cb @(posedge aclk);
	endclocking
	default disable iff (!aresetn);

	property p_j_dir;
		!$past(bus_en) && HJ_PRESENT |-> j_oe == ~$past(j_dir_reg);
	endproperty
	a_j_dir: assert property (p_j_dir) // R1
		else $error("port J drive does not follow direction");

	property p_lat_rmw;
		ar_hs && rd_addr == OFF_H_LAT && s_araddr[31:ADDR_W] == '0
		|=> s_rdata[7:0] == $past(h_lat_reg) && s_rvalid;
	endproperty
	a_lat_rmw: assert property (p_lat_rmw) // R2
		else $error("latch read does not return stored latch");

	property p_h_addr;
		$past(bus_en) && HJ_PRESENT |-> h_oe[3:0] == 4'hF
			&& h_out[3:0] == $past(mem_bus.addr_hi);
	endproperty
	a_h_addr: assert property (p_h_addr) // R4
		else $error("address lines not on port H");

	property p_pwm;
		!$past(pwm_pin_swap_fuse) && HJ_PRESENT
		|-> h_out[7:4] == $past(pwm_alt.level);
	endproperty
	a_pwm: assert property (p_pwm) // R6
		else $error("PWM level missing on port H");

	property p_pwm_hiz;
		!$past(pwm_pin_swap_fuse) |-> (h_oe[7:4] & $past(pwm_alt.hiz)) == 4'h0;
	endproperty
	a_pwm_hiz: assert property (p_pwm_hiz) // R7
		else $error("PWM pin driven during shutdown");

	property p_absent;
		!HJ_PRESENT |-> h_oe == ALL_OFF && j_oe == ALL_OFF;
	endproperty
	a_absent: assert property (p_absent) // R8
		else $error("absent port drives a pin");

	property p_j_bus;
		$past(bus_en) && HJ_PRESENT |-> j_oe == ALL_ON
			&& j_out == $past(mem_bus.strobes);
	endproperty
	a_j_bus: assert property (p_j_bus) // R11
		else $error("bus strobes not on port J");

	property p_pullup;
		(j_pullup & j_oe) == ALL_OFF
		and (!$past(j_pullup_enable_reg) |-> j_pullup == ALL_OFF);
	endproperty
	a_pullup: assert property (p_pullup) // R14
		else $error("pull-up on a driven or disabled pin");

	property p_pin_write;
		wr_fire && wr_mapped && wr_lane0 && wr_addr == OFF_J_PIN
		|=> j_lat_reg == $past(wr_data) ##1 j_out == $past(j_lat_reg)
			|| $past(bus_en);
	endproperty
	a_pin_write: assert property (p_pin_write) // R16
		else $error("pin register write missed the latch");

	property p_dir_keep;
		!(wr_fire && wr_addr == OFF_J_DIR) |=> $stable(j_dir_reg);
	endproperty
	a_dir_keep: assert property (p_dir_keep) // R17
		else $error("direction changed without a write");
endmodule : hj_port

// ### bench/hj_pin_model.sv
`timescale 1ns/100ps
// Board-side view of the H and J pins: drivers, pull-ups and floating lines
module hj_pin_model (
	input wire logic aclk, // System clock, paces the floating pattern
	input wire logic [7:0] h_out, // Port H drive level
	input wire logic [7:0] h_oe, // Port H drive enable
	input wire logic [7:0] j_out, // Port J drive level
	input wire logic [7:0] j_oe, // Port J drive enable
	input wire logic [7:0] j_pullup, // Port J weak pull-up enable
	input wire logic [7:0] ext_h, // Board drive on H, always present
	input wire logic [7:0] ext_j, // Board drive level on J
	input wire logic [7:0] ext_j_en, // Board drives that J pin
	output logic [7:0] h_in, // Resolved H pin levels
	output logic [7:0] j_in // Resolved J pin levels
);
	logic flt = 1'b0; // Unheld line wanders every cycle
	// Toggle so a floating pin never settles on a lucky value
	always @(posedge aclk) flt <= ~flt;
	// Device drive wins over the board
	assign h_in = (h_oe & h_out) | (~h_oe & ext_h);
	// Pull-up only holds a pin nobody drives
	always_comb begin
		for (int i = 0; i < 8; i++) begin
			if (j_oe[i]) j_in[i] = j_out[i];
			else if (ext_j_en[i]) j_in[i] = ext_j[i];
			else if (j_pullup[i]) j_in[i] = 1'b1;
			else j_in[i] = flt;
		end
	end
endmodule : hj_pin_model

// ### bench/dual_gpio_port_with_bus_override_tb.sv
`timescale 1ns/100ps
module dual_gpio_port_with_bus_override_tb;
	import hj_port_pkg::*;
	logic aclk = 0, aresetn = 0;
	logic [31:0] s_awaddr = 0, s_wdata = 0, s_araddr = 0, s_rdata;
	logic [3:0] s_wstrb = 4'hF;
	logic s_awvalid = 0, s_wvalid = 0, s_bready = 0, s_arvalid = 0;
	logic s_rready = 0, s_awready, s_wready, s_bvalid, s_arready, s_rvalid;
	logic [1:0] s_bresp, s_rresp, got_resp;
	mem_bus_t mem_bus = '{1'b1, 4'h0, 8'h00}; // Bus off at start
	pwm_alt_t pwm_alt = '0;
	logic fuse = 1'b1; // PWM on its default pins
	logic [3:0] analog_sel;
	logic [7:0] h_in, h_out, h_oe, j_in, j_out, j_oe, j_pullup;
	logic [7:0] ext_h = 0, ext_j = 0, ext_j_en = 0, got;
	int miscompares = 0, check_count = 0;
	always #2 aclk = ~aclk; // 250 MHz
	hj_port #(.HJ_PRESENT(1'b1)) u_hj_port (.aclk(aclk), .aresetn(aresetn),
		.s_awaddr(s_awaddr), .s_awvalid(s_awvalid), .s_awready(s_awready),
		.s_wdata(s_wdata), .s_wstrb(s_wstrb), .s_wvalid(s_wvalid),
		.s_wready(s_wready), .s_bresp(s_bresp), .s_bvalid(s_bvalid),
		.s_bready(s_bready), .s_araddr(s_araddr), .s_arvalid(s_arvalid),
		.s_arready(s_arready), .s_rdata(s_rdata), .s_rresp(s_rresp),
		.s_rvalid(s_rvalid), .s_rready(s_rready), .mem_bus(mem_bus),
		.pwm_alt(pwm_alt), .pwm_pin_swap_fuse(fuse), .analog_sel(analog_sel),
		.h_in(h_in), .h_out(h_out), .h_oe(h_oe), .j_in(j_in), .j_out(j_out),
		.j_oe(j_oe), .j_pullup(j_pullup));
	hj_pin_model u_hj_pin_model (.aclk(aclk), .h_out(h_out), .h_oe(h_oe),
		.j_out(j_out), .j_oe(j_oe), .j_pullup(j_pullup), .ext_h(ext_h),
		.ext_j(ext_j), .ext_j_en(ext_j_en), .h_in(h_in), .j_in(j_in));
	// Verdict in one place
	task automatic end_sim();
		$display("checks %0d mismatches %0d", check_count, miscompares);
		if (miscompares == 0 && check_count > 0) $display("Test passed");
		else $display("Test failed");
		$finish;
	endtask : end_sim
	task automatic chk(string what, logic [31:0] exp, logic [31:0] seen);
		check_count++;
		if (seen !== exp) begin
			$display("[FAIL] %s expected %h seen %h", what, exp, seen);
			miscompares++;
		end
	endtask : chk
	// Out of patience: count it and close
	task automatic give_up(int n);
		if (n >= 50) begin
			miscompares++;
			$display("[FAIL] handshake expected answer seen none");
			end_sim();
		end
	endtask : give_up
	// Write: address and data offered together, each released when taken
	task automatic wr(logic [31:0] a, logic [7:0] d);
		bit da, dw, ta, tw;
		int n;
		da = 0; dw = 0; n = 0;
		@(posedge aclk);
		s_awaddr <= a; s_awvalid <= 1; s_wdata <= {24'h0, d};
		s_wvalid <= 1; s_bready <= 1;
		while (!(da && dw) && n < 50) begin
			@(negedge aclk);
			ta = !da && s_awready; tw = !dw && s_wready;
			@(posedge aclk);
			if (ta) s_awvalid <= 0;
			if (tw) s_wvalid <= 0;
			da |= ta; dw |= tw; n++;
		end
		do begin @(negedge aclk); n++; end while (!s_bvalid && n < 50);
		give_up(n);
		got_resp = s_bresp;
		@(posedge aclk) s_bready <= 0;
	endtask : wr
	// Read: hold the request until arready, then wait for the data
	task automatic rd(logic [31:0] a);
		int n;
		n = 0;
		@(posedge aclk);
		s_araddr <= a; s_arvalid <= 1; s_rready <= 1;
		do begin @(negedge aclk); n++; end while (!s_arready && n < 50);
		@(posedge aclk) s_arvalid <= 0;
		do begin @(negedge aclk); n++; end while (!s_rvalid && n < 50);
		give_up(n);
		got = s_rdata[7:0]; got_resp = s_rresp;
		@(posedge aclk) s_rready <= 0;
	endtask : rd
	task automatic rchk(string what, logic [31:0] a, logic [7:0] exp);
		rd(a);
		chk(what, {24'h0, exp}, {24'h0, got});
	endtask : rchk
	// Let outputs and the input synchronisers settle
	task automatic settle();
		repeat (4) @(posedge aclk);
	endtask : settle
	initial begin
		repeat (16) @(posedge aclk);
		aresetn <= 1;
		settle();
		// Reset state of registers and pins
		rchk("h_dir", OFF_H_DIR, RST_DIR);
		rchk("j_dir", OFF_J_DIR, RST_DIR);
		rchk("h_lat", OFF_H_LAT, RST_LAT);
		rchk("g_ctl", OFF_G_CTL, 8'h00);
		rchk("ana", OFF_ANA_CFG, {4'h0, RST_ANA});
		chk("analog_sel", 32'hF, {28'h0, analog_sel});
		chk("j_oe", 0, {24'h0, j_oe});
		chk("j_pullup", 0, {24'h0, j_pullup});
		$display("reset test done");
		// Port H direction per pin, pin readback
		wr(OFF_ANA_CFG, 8'h04);
		chk("analog_sel dig", 0, {28'h0, analog_sel});
		wr(OFF_H_LAT, 8'hA5);
		chk("bresp", {30'h0, RESP_OKAY}, {30'h0, got_resp});
		wr(OFF_H_DIR, 8'h0F);
		ext_h <= 8'h3C;
		settle();
		chk("h_oe", 32'hF0, {24'h0, h_oe});
		chk("h_out", 32'hA0, {24'h0, h_out & 8'hF0});
		rchk("h_pin", OFF_H_PIN, 8'hAC);
		rchk("h_lat kept", OFF_H_LAT, 8'hA5);
		wr(OFF_ANA_CFG, 8'h02);
		chk("analog_sel part", 32'h3, {28'h0, analog_sel});
		chk("h_out analog", 32'hA0, {24'h0, h_out & 8'hF0});
		rchk("h_pin analog", OFF_H_PIN, 8'h8C);
		$display("port h test done");
		// Latch reads back latch, pin register writes latch
		wr(OFF_J_LAT, 8'h3C);
		ext_j <= 8'hC3; ext_j_en <= 8'hFF;
		settle();
		rchk("j_lat", OFF_J_LAT, 8'h3C);
		rchk("j_pin", OFF_J_PIN, 8'hC3);
		wr(OFF_J_PIN, 8'h5A);
		rchk("j_lat wr pin", OFF_J_LAT, 8'h5A);
		$display("latch test done");
		// Pull-ups only on undriven pins, one control bit
		ext_j_en <= 8'h00;
		wr(OFF_J_DIR, 8'hF0);
		wr(OFF_G_CTL, 8'h20);
		settle();
		chk("j_pullup", 32'hF0, {24'h0, j_pullup});
		rchk("j_pin pulled", OFF_J_PIN, 8'hFA);
		rchk("g_ctl", OFF_G_CTL, 8'h20);
		wr(OFF_G_CTL, 8'h00);
		settle();
		chk("j_pullup off", 0, {24'h0, j_pullup});
		wr(OFF_G_CTL, 8'h20);
		$display("pull-up test done");
		// Memory bus takes over J and H low nibble
		mem_bus <= '{1'b0, 4'h9, 8'h96};
		settle();
		chk("j_oe bus", 32'hFF, {24'h0, j_oe});
		chk("j_out bus", 32'h96, {24'h0, j_out});
		chk("j_pullup bus", 0, {24'h0, j_pullup});
		chk("h_oe bus", 32'hF, {28'h0, h_oe[3:0]});
		chk("h_out bus", 32'h9, {28'h0, h_out[3:0]});
		rchk("j_dir kept", OFF_J_DIR, 8'hF0);
		rchk("h_dir kept", OFF_H_DIR, 8'h0F);
		mem_bus <= '{1'b1, 4'h0, 8'h00};
		$display("bus test done");
		// PWM mapped onto H high nibble, then floated on shutdown
		fuse <= 0; pwm_alt <= '{4'h6, 4'h0};
		settle();
		chk("h_out pwm", 32'h6, {28'h0, h_out[7:4]});
		chk("h_oe pwm", 32'hF, {28'h0, h_oe[7:4]});
		pwm_alt <= '{4'h6, 4'hF};
		settle();
		chk("h_oe hiz", 32'h0, {28'h0, h_oe[7:4]});
		fuse <= 1;
		$display("pwm test done");
		// Unmapped offset refused; write with lane 0 strobe off answers OKAY but changes nothing
		rd(32'h20);
		chk("rresp", {30'h0, RESP_SLVERR}, {30'h0, got_resp});
		chk("rdata", 0, {24'h0, got});
		wr(32'h20, 8'hFF);
		chk("bresp unmapped", {30'h0, RESP_SLVERR}, {30'h0, got_resp});
		s_wstrb <= 4'hE;
		wr(OFF_H_LAT, 8'h00);
		chk("bresp lane", {30'h0, RESP_OKAY}, {30'h0, got_resp});
		s_wstrb <= 4'hF;
		rchk("h_lat untouched", OFF_H_LAT, 8'hA5);
		$display("unmapped test done");
		// Reset in mid-run returns J to inputs, pull-ups off
		wr(OFF_J_DIR, 8'h00);
		aresetn <= 0;
		repeat (2) @(posedge aclk);
		aresetn <= 1;
		settle();
		chk("j_oe rst", 0, {24'h0, j_oe});
		chk("j_pullup rst", 0, {24'h0, j_pullup});
		rchk("j_dir rst", OFF_J_DIR, RST_DIR);
		rchk("g_ctl rst", OFF_G_CTL, 8'h00);
		$display("second reset test done");
		end_sim();
	end
endmodule : dual_gpio_port_with_bus_override_tb
